// [serial_peer_model.sv]
// far-side slave for the serial port: answers a reply word, keeps captured words
// assumes the design is master and drives clock and select
`timescale 1ns/1ps
module serial_peer_model (
  input wire logic sclk_i,
  input wire logic fss_i,
  input wire logic mosi_i,
  input wire logic fmt_i,
  input wire logic pol_i,
  input wire logic ph_i,
  input wire logic [3:0] size_i,
  input wire logic [15:0] reply_i,
  output logic miso_o
);
  logic [15:0] rep = '0;
  logic [15:0] sh = '0;
  logic [15:0] got_q[$];
  logic last = 1'b0;
  int idx = 0;
  int cnt = 0;
  bit act = 0;
  bit first = 0;
  // incoming bit into the shifter, a whole word is kept
  task automatic cap();
    sh = {sh[14:0], mosi_i};
    cnt++;
    if (cnt == size_i + 1) begin
      got_q.push_back(sh);
      cnt = 0;
    end
  endtask
  // next outgoing bit, msb first, wraps for the next word
  task automatic shift();
    if (first) first = 0;
    else idx = (idx == 0) ? size_i : idx - 1;
  endtask
  // select fall loads the reply, msb out at once for phase 0
  always @(negedge fss_i) if (fmt_i) begin
    rep = reply_i;
    idx = size_i;
    cnt = 0;
    first = ph_i;
    act = 1;
  end
  always @(posedge fss_i) if (fmt_i) act = 0;
  // rising edge: capture or change by mode
  always @(posedge sclk_i) if (act) begin
    if (fmt_i && pol_i == ph_i) cap();
    else shift();
  end
  // falling edge inside the pulse loads the reply, msb out before first rise
  always @(negedge sclk_i) begin
    if (!fmt_i && fss_i) begin
      rep = reply_i;
      idx = size_i;
      cnt = 0;
      first = 1;
      act = 1;
    end else if (act) begin
      if (!fmt_i || pol_i != ph_i) cap();
      else shift();
    end
  end
  // released line shows the inverse of its last value
  always @* begin
    if (act) miso_o = rep[idx];
    else miso_o = ~last;
    if (act) last = miso_o;
  end
endmodule // serial_peer_model

// [serial_port_checker.sv]
// pin timing assertions for the serial port in master runs
// assumes bound to sync_serial_port, settings changed only while disabled
`timescale 1ns/1ps
module serial_port_checker import sync_serial_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic port_enable_bit_i,
  input wire logic master_mode_i,
  input wire logic frame_format_i,
  input wire logic clock_idle_polarity_i,
  input wire logic capture_phase_i,
  input wire logic [DIV_W-1:0] prescale_divisor_i,
  input wire logic [DIV_W-1:0] serial_rate_factor_i,
  input wire logic rx_valid_o,
  input wire logic serial_clock_line_o,
  input wire logic serial_clock_line_oe_o,
  input wire logic frame_select_line_o,
  input wire logic serial_out_line_o,
  input wire logic serial_out_line_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  int half;
  int fss_cnt_ff, clk_cnt_ff, rx_cnt_ff, hi_ff;
  logic en_ff, first_ff, run, spi;
  // system cycles per half bit, settled master run
  assign half = int'(prescale_divisor_i[7:1]) * (int'(serial_rate_factor_i) + 1);
  assign run = port_enable_bit_i && en_ff && master_mode_i;
  assign spi = run && frame_format_i;
  // cycle counts since select fall, clock toggle, receive push
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_ff <= 1'b0;
      first_ff <= 1'b0;
      fss_cnt_ff <= 0;
      clk_cnt_ff <= 0;
      rx_cnt_ff <= 0;
      hi_ff <= 0;
    end else begin
      en_ff <= port_enable_bit_i;
      first_ff <= $fell(frame_select_line_o) ? 1'b1
        : ($changed(serial_clock_line_o) ? 1'b0 : first_ff);
      fss_cnt_ff <= $fell(frame_select_line_o) ? 1 : fss_cnt_ff + 1;
      clk_cnt_ff <= $changed(serial_clock_line_o) ? 1 : clk_cnt_ff + 1;
      rx_cnt_ff <= rx_valid_o ? 1 : rx_cnt_ff + 1;
      hi_ff <= frame_select_line_o ? hi_ff + 1 : 0;
    end
  end
  sequence s_idle;
    spi && frame_select_line_o && $past(frame_select_line_o);
  endsequence
  sequence s_tog;
    spi && $changed(serial_clock_line_o);
  endsequence
  a_idle_clk: assert property (
    s_idle |-> serial_clock_line_o == clock_idle_polarity_i) else $error("clock not idle");
  a_idle_out: assert property (
    s_idle |-> !serial_out_line_o) else $error("idle output not low");
  a_clk_pad: assert property (
    spi |-> serial_clock_line_oe_o) else $error("master clock pad off");
  a_pulse_pad: assert property (
    run && !frame_format_i && $rose(serial_out_line_oe_o)
    |-> $past(frame_select_line_o) && !frame_select_line_o) else $error("output before pulse");
  a_pulse_width: assert property (
    run && !frame_format_i && $fell(frame_select_line_o) |-> hi_ff == 2 * half)
    else $error("pulse width wrong");
  a_half_rate: assert property (
    s_tog ##0 serial_clock_line_o == clock_idle_polarity_i |-> clk_cnt_ff == half)
    else $error("half period wrong");
  a_first_edge: assert property (
    s_tog ##0 first_ff |-> fss_cnt_ff == (capture_phase_i ? half : 2 * half))
    else $error("first clock edge late");
  a_sel_trail: assert property (
    spi && $rose(frame_select_line_o) |-> rx_cnt_ff == half) else $error("select rise late");
  a_push_once: assert property (
    rx_valid_o |=> !rx_valid_o) else $error("push longer than one cycle");
endmodule // serial_port_checker
bind sync_serial_port serial_port_checker i_chk (.sys_clk_i, .rst_n_i, .port_enable_bit_i,
  .master_mode_i, .frame_format_i, .clock_idle_polarity_i, .capture_phase_i,
  .prescale_divisor_i, .serial_rate_factor_i, .rx_valid_o, .serial_clock_line_o,
  .serial_clock_line_oe_o, .frame_select_line_o, .serial_out_line_o, .serial_out_line_oe_o);

// [sync_serial_pkg.sv]
// constants, state type and field layout for the synchronous serial port
// assumes one 20 MHz system clock and FIFO heads outside this block
package sync_serial_pkg;
  localparam int WORD_W = 16;
  localparam int SIZE_W = 4;
  localparam int DIV_W = 8;
  localparam int HALF_W = 5;
  localparam logic FMT_PULSE = 1'b0; // pulse-framed synchronous format
  localparam logic FMT_SPI = 1'b1;
  localparam logic [SIZE_W-1:0] SIZE_MIN = 4'h3; // size field holds bits minus one

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PULSE = 3'b001,
    ST_LEAD = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_TRAIL = 3'b100
  } mstate_type;

  typedef struct packed {
    mstate_type st;
    logic [DIV_W-1:0] pre_cnt;
    logic [DIV_W-1:0] rate_cnt;
    logic [HALF_W-1:0] half;
    logic [SIZE_W-1:0] bit_cnt;
    logic [WORD_W-1:0] sh_tx;
    logic [WORD_W-1:0] sh_rx;
    logic [WORD_W-1:0] rx_data;
    logic rx_valid;
    logic sclk;
    logic fss;
    logic tx_line;
    logic tx_oe;
    logic slv_active;
    logic slv_first;
    logic [1:0] clk_sync;
    logic clk_prev;
    logic [1:0] fss_sync;
    logic fss_prev;
  } port_state_type;

  localparam port_state_type STATE_RESET = '0;
endpackage

// [sync_serial_port.sv]
// serial frame engine: pulse-framed and SPI formats, master or slave
// assumes FIFO heads on the parallel side and pin pads that resolve enables
`timescale 1ns/1ps
module sync_serial_port import sync_serial_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic port_enable_bit_i,
  input wire logic master_mode_i,
  input wire logic frame_format_i,
  input wire logic clock_idle_polarity_i,
  input wire logic capture_phase_i,
  input wire logic [SIZE_W-1:0] data_size_i,
  input wire logic [DIV_W-1:0] prescale_divisor_i,
  input wire logic [DIV_W-1:0] serial_rate_factor_i,
  input wire logic [WORD_W-1:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [WORD_W-1:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic serial_clock_line_i,
  output logic serial_clock_line_o,
  output logic serial_clock_line_oe_o,
  input wire logic frame_select_line_i,
  output logic frame_select_line_o,
  output logic frame_select_line_oe_o,
  output logic serial_out_line_o,
  output logic serial_out_line_oe_o,
  input wire logic serial_in_line_i
);

  port_state_type q;
  port_state_type n;
  logic [SIZE_W-1:0] size;
  logic [HALF_W-1:0] last_half;
  logic [WORD_W-1:0] rx_mask;
  logic spi;
  logic pol;
  logic [DIV_W-1:0] pre_top;
  logic half_tick;
  logic load;
  logic clk_rise;
  logic clk_fall;
  logic fss_rise;
  logic fss_fall;
  logic lead_edge;
  logic trail_edge;
  logic cap_edge;
  logic chg_edge;

  // decoded configuration, stable while the port is enabled
  assign size = (data_size_i < SIZE_MIN) ? SIZE_MIN : data_size_i;
  assign last_half = {size, 1'b1};
  assign rx_mask = WORD_W'((17'h1_0000 >> (4'hf - size)) - 17'h1);
  assign spi = (frame_format_i == FMT_SPI);
  assign pol = spi & clock_idle_polarity_i;
  assign pre_top = {1'b0, prescale_divisor_i[DIV_W-1:1]} - 8'h1;

  // slave edge detection on synchronised pins, second stage against previous
  assign clk_rise = q.clk_sync[1] & ~q.clk_prev;
  assign clk_fall = ~q.clk_sync[1] & q.clk_prev;
  assign fss_rise = q.fss_sync[1] & ~q.fss_prev;
  assign fss_fall = ~q.fss_sync[1] & q.fss_prev;
  assign lead_edge = pol ? clk_fall : clk_rise;
  assign trail_edge = pol ? clk_rise : clk_fall;

  // capture and change edges per format and phase
  always_comb begin
    if (!spi) begin
      cap_edge = clk_fall;
      chg_edge = clk_rise;
    end else if (!capture_phase_i) begin
      cap_edge = lead_edge;
      chg_edge = trail_edge;
    end else begin
      cap_edge = trail_edge;
      chg_edge = lead_edge;
    end
  end

  // next-state logic for divider, master sequencer and slave shifter
  always_comb begin
    n = q;
    half_tick = 1'b0;
    load = 1'b0;
    n.rx_valid = 1'b0;
    n.clk_sync = {q.clk_sync[0], serial_clock_line_i};
    n.clk_prev = q.clk_sync[1];
    n.fss_sync = {q.fss_sync[0], frame_select_line_i};
    n.fss_prev = q.fss_sync[1];
    if (!port_enable_bit_i) begin
      // disabled: park every line at its idle level
      n.st = ST_IDLE;
      n.pre_cnt = '0;
      n.rate_cnt = '0;
      n.sclk = pol;
      n.fss = spi;
      n.tx_line = 1'b0;
      n.tx_oe = spi & master_mode_i;
      n.slv_active = 1'b0;
    end else if (master_mode_i) begin
      // half-period tick: prescale/2 cycles, then 1 + rate factor of those
      if (q.pre_cnt >= pre_top) begin
        n.pre_cnt = '0;
        if (q.rate_cnt >= serial_rate_factor_i) begin
          n.rate_cnt = '0;
          half_tick = 1'b1;
        end else begin
          n.rate_cnt = q.rate_cnt + 8'h1;
        end
      end else begin
        n.pre_cnt = q.pre_cnt + 8'h1;
      end
      if (half_tick) begin
        case (q.st)
          ST_IDLE: begin
            n.sclk = pol;
            n.fss = spi;
            n.tx_line = 1'b0;
            n.tx_oe = spi;
            if (tx_valid_i) begin
              load = 1'b1;
              n.sh_tx = tx_data_i;
              n.half = '0;
              if (!spi) begin
                n.st = ST_PULSE;
                n.fss = 1'b1;
                n.sclk = 1'b1;
              end else begin
                n.st = ST_LEAD;
                n.fss = 1'b0;
                n.tx_oe = 1'b1;
              end
            end
          end
          ST_PULSE: begin
            if (q.half == '0) begin
              n.half = 5'h1;
              n.sclk = 1'b0;
            end else begin
              // rising edge after the pulse: frame-select drops, MSB out
              n.st = ST_ACTIVE;
              n.half = '0;
              n.fss = 1'b0;
              n.sclk = 1'b1;
              n.tx_oe = 1'b1;
              n.tx_line = q.sh_tx[size];
            end
          end
          ST_LEAD: begin
            // half period after select falls: first bit out
            n.st = ST_ACTIVE;
            n.tx_line = q.sh_tx[size];
            n.sclk = pol ^ capture_phase_i;
          end
          ST_ACTIVE: begin
            if (!q.half[0]) begin
              n.sh_rx = {q.sh_rx[WORD_W-2:0], serial_in_line_i};
              n.sclk = ~q.sclk;
              n.half = q.half + 5'h1;
            end else if (q.half != last_half) begin
              n.sh_tx = {q.sh_tx[WORD_W-2:0], 1'b0};
              n.tx_line = q.sh_tx[size - 4'h1];
              n.sclk = ~q.sclk;
              n.half = q.half + 5'h1;
            end else begin
              // word complete: hand it to the receive side
              n.rx_data = q.sh_rx & rx_mask;
              n.rx_valid = 1'b1;
              n.half = '0;
              if (!spi) begin
                n.st = ST_IDLE;
                n.sclk = 1'b0;
                n.tx_oe = 1'b0;
                n.tx_line = 1'b0;
              end else if (capture_phase_i && tx_valid_i) begin
                // phase 1 run: select stays low, next word follows
                load = 1'b1;
                n.sh_tx = tx_data_i;
                n.tx_line = tx_data_i[size];
                n.sclk = ~pol;
              end else begin
                n.st = ST_TRAIL;
                n.sclk = pol;
              end
            end
          end
          ST_TRAIL: begin
            // select rises one period after the last capture
            n.st = ST_IDLE;
            n.fss = 1'b1;
            n.tx_line = 1'b0;
          end
          default: begin
            n.st = ST_IDLE;
          end
        endcase
      end
    end else begin
      // slave: driven only by detected edges of the external clock and select
      n.st = ST_IDLE;
      n.sclk = pol;
      n.fss = spi;
      if (spi && fss_rise) begin
        n.slv_active = 1'b0;
        n.tx_oe = 1'b0;
        n.tx_line = 1'b0;
      end else if (spi && fss_fall) begin
        load = tx_valid_i;
        n.sh_tx = tx_valid_i ? tx_data_i : '0;
        n.tx_line = tx_valid_i ? tx_data_i[size] : 1'b0;
        n.tx_oe = 1'b1;
        n.slv_active = 1'b1;
        n.slv_first = capture_phase_i;
        n.bit_cnt = '0;
      end else if (!spi && !q.slv_active && clk_fall && q.fss_sync[1]) begin
        // frame pulse seen: arm and present the MSB
        load = tx_valid_i;
        n.sh_tx = tx_valid_i ? tx_data_i : '0;
        n.tx_line = tx_valid_i ? tx_data_i[size] : 1'b0;
        n.tx_oe = 1'b1;
        n.slv_active = 1'b1;
        n.slv_first = 1'b1;
        n.bit_cnt = '0;
      end else if (q.slv_active && chg_edge) begin
        if (q.slv_first) begin
          n.slv_first = 1'b0;
        end else begin
          n.sh_tx = {q.sh_tx[WORD_W-2:0], 1'b0};
          n.tx_line = q.sh_tx[size - 4'h1];
        end
      end else if (q.slv_active && cap_edge) begin
        n.sh_rx = {q.sh_rx[WORD_W-2:0], serial_in_line_i};
        n.bit_cnt = q.bit_cnt + 4'h1;
        if (q.bit_cnt == size) begin
          n.rx_data = {q.sh_rx[WORD_W-2:0], serial_in_line_i} & rx_mask;
          n.rx_valid = 1'b1;
          n.bit_cnt = '0;
          if (!spi) begin
            n.slv_active = 1'b0;
            n.tx_oe = 1'b0;
            n.tx_line = 1'b0;
          end else if (capture_phase_i) begin
            // phase 1 slave reloads while still selected
            load = tx_valid_i;
            n.sh_tx = tx_valid_i ? tx_data_i : '0;
            n.slv_first = 1'b1;
          end else begin
            n.slv_active = 1'b0; // frozen until the next deselect
          end
        end
      end
    end
  end

  // single state register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= STATE_RESET;
    end else begin
      q <= n;
    end
  end

  // pin and FIFO-side outputs
  assign tx_ready_o = load;
  assign rx_data_o = q.rx_data;
  assign rx_valid_o = q.rx_valid;
  assign serial_clock_line_o = q.sclk;
  assign serial_clock_line_oe_o = port_enable_bit_i & master_mode_i;
  assign frame_select_line_o = q.fss;
  assign frame_select_line_oe_o = port_enable_bit_i & master_mode_i;
  assign serial_out_line_o = q.tx_line;
  assign serial_out_line_oe_o = q.tx_oe;

endmodule // sync_serial_port

// [tb_sync_serial_port.sv]
// testbench: master runs of every format, mode and two word sizes
// assumes the peer model answers on the serial pins
`timescale 1ns/1ps
module tb_sync_serial_port;
  import sync_serial_pkg::*;
  logic clk = 0, rst_n = 0, en = 0, fmt = 0, pol = 0, ph = 0, txv = 0, mst = 1;
  logic [3:0] size = 4'h3;
  logic [7:0] rate = 8'h00;
  logic [15:0] txd = 16'h0000, reply = 16'h0000, mask = 16'h000f, rxd;
  logic [15:0] words[2];
  logic rdy, rxv, sck, sck_oe, fss, fss_oe, sdo, sdo_oe, sdi;
  int seed = 4, fail_count = 0, total_checks = 0, sent = 0, got = 0, cyc = 0;
  always #25 clk = ~clk;
  sync_serial_port i_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .port_enable_bit_i(en),
    .master_mode_i(mst), .frame_format_i(fmt), .clock_idle_polarity_i(pol),
    .capture_phase_i(ph), .data_size_i(size), .prescale_divisor_i(8'h04),
    .serial_rate_factor_i(rate), .tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(rdy),
    .rx_data_o(rxd), .rx_valid_o(rxv), .serial_clock_line_i(sck), .serial_clock_line_o(sck),
    .serial_clock_line_oe_o(sck_oe), .frame_select_line_i(fss), .frame_select_line_o(fss),
    .frame_select_line_oe_o(fss_oe), .serial_out_line_o(sdo), .serial_out_line_oe_o(sdo_oe),
    .serial_in_line_i(sdi));
  serial_peer_model i_peer (.sclk_i(sck), .fss_i(fss), .mosi_i(sdo), .fmt_i(fmt),
    .pol_i(pol), .ph_i(ph), .size_i(size), .reply_i(reply), .miso_o(sdi));
  task automatic check(input logic [15:0] a, input logic [15:0] e);
    total_checks++;
    if (a !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // mid-cycle: count pops and pushes, check pushed words, then move the head
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      fail_count++;
      end_sim();
    end
    if (rdy) sent <= sent + 1;
    if (rxv) got <= got + 1;
    if (rxv) check(rxd, reply & mask);
    txv = en && sent < 2;
    txd = words[sent & 1];
  end
  // one run: two back-to-back words, then idle line levels
  task automatic run(input logic f, input logic p, input logic h, input logic [3:0] s);
    en = 0;
    fmt = f;
    pol = p;
    ph = h;
    size = s;
    rate = 8'($random(seed) & 1);
    words[0] = 16'($random(seed));
    words[1] = 16'($random(seed));
    reply = 16'($random(seed));
    mask = 16'hffff >> (15 - s);
    sent = 0;
    got = 0;
    i_peer.got_q.delete();
    repeat (3) @(negedge clk);
    en = 1;
    for (int i = 0; i < 4000 && got < 2; i++) @(negedge clk);
    repeat (24) @(negedge clk);
    check(16'(got), 16'h0002);
    check(16'(i_peer.got_q.size()), 16'h0002);
    if (i_peer.got_q.size() == 2)
      for (int k = 0; k < 2; k++) check(i_peer.got_q[k] & mask, words[k] & mask);
    check({fss, sck, sdo & sdo_oe, sdo_oe, sck_oe, fss_oe},
      f ? {10'h000, 1'b1, p, 4'h7} : 16'h0003);
  endtask
  // pulse format then the four clock modes, four and sixteen bits each
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    for (int m = 0; m < 10; m++) run(m > 1, m > 5, m == 4 || m == 5 || m > 7, m[0] ? 4'hf : 4'h3);
    // idle slave: no pad driven
    en = 0;
    mst = 0;
    fmt = 1;
    repeat (3) @(negedge clk);
    en = 1;
    repeat (8) @(negedge clk);
    check({13'h0, sck_oe, fss_oe, sdo_oe}, 16'h0000);
    end_sim();
  end
endmodule // tb_sync_serial_port
